//--- pkg/rmu_pkg.sv
/*
  rmu_pkg: shared constants and types of the rotate-and-mask unit.
  assumes: included before the interface and the design modules; holds no logic.
*/
package rmu_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned CR_FIELD_W = 4;

  // ==========================================================================
  // condition field zero layout, little-endian index within the nibble
  localparam int unsigned CR0_LT_BIT = 3;
  localparam int unsigned CR0_GT_BIT = 2;
  localparam int unsigned CR0_EQ_BIT = 1;
  localparam int unsigned CR0_SO_BIT = 0;

  // ==========================================================================
  // reset values
  localparam logic [WORD_W-1:0]     RESULT_RST = 32'h0000_0000;
  localparam logic [CR_FIELD_W-1:0] CR0_RST    = 4'h0;
  localparam logic [CNT_W-1:0]      CNT_RST    = 5'h00;

  // ==========================================================================
  // timing: clock period and the issue-to-result latency in cycles
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned LATENCY_CYCLES = 2;

  // ==========================================================================
  // operation select, one-hot; the other two codes are illegal
  typedef enum logic [1:0] {
    RMU_OP_ROT_AND    = 2'h1,
    RMU_OP_ROT_INSERT = 2'h2
  } rmu_op_e;

endpackage : rmu_pkg

//--- pkg/rmu_mask_if.sv
/*
  rmu_mask_if: carries the mask bounds to the mask generator and the mask back.
  assumes: both ends run combinationally on the same clock domain.
*/
`timescale 1ns/1ps
interface rmu_mask_if;
  logic [rmu_pkg::CNT_W-1:0]  mask_begin;
  logic [rmu_pkg::CNT_W-1:0]  mask_end;
  logic [rmu_pkg::WORD_W-1:0] mask;

  modport gen  (input mask_begin, input mask_end, output mask);
  modport user (output mask_begin, output mask_end, input mask);
endinterface : rmu_mask_if

//--- rtl/rmu_mask_gen.sv
/*
  rmu_mask_gen: builds the 32-bit mask from mask_begin through mask_end.
  assumes: bit numbering is big-endian (bit 0 is the msb, vector index 31);
  bounds arrive settled from registers of the caller.
*/
`timescale 1ns/1ps
module rmu_mask_gen (
  rmu_mask_if.gen m
);

  // ==========================================================================
  // mask decode
  // one comparator pair per bit keeps the path flat instead of a shifter chain
  always_comb begin
    logic [rmu_pkg::CNT_W-1:0] pos;
    pos = '0;
    for (int i = 0; i < rmu_pkg::WORD_W; i++) begin
      pos = rmu_pkg::CNT_W'(rmu_pkg::WORD_W - 1 - i);
      if (m.mask_begin <= m.mask_end) begin
        m.mask[i] = (pos >= m.mask_begin) && (pos <= m.mask_end);
      end else begin
        m.mask[i] = (pos >= m.mask_begin) || (pos <= m.mask_end);
      end
    end
  end

endmodule // rmu_mask_gen

//--- rtl/rmu_top.sv
/*
  rmu_top: rotate-and-mask datapath of the integer unit, two-cycle pipeline.
  holds the operand capture stage, the rotate, the mask use, the insert, and
  the condition field zero update for the record variants.
  assumes: the decoder and register file drive the issue port from logic on
  the same clock, so no input synchroniser is used; the caller writes
  result into the destination register and condition_field_zero into the
  condition register when the matching write strobes are high.
*/
`timescale 1ns/1ps

// Overview of operation
// - the variable form rotates the source left by the low five bits of the count register.
// - the mask has ones from the mask_begin bit through the mask_end bit, zeros elsewhere.
// - the variable form ands the rotated source with the mask and writes the destination.
// - record variants also update the condition register; plain ones leave it alone.
// - the insert form rotates the source left by the immediate shift amount.
// - the insert form takes rotated bits under the mask, old destination bits outside it.
// - with a full mask the variable form is a pure rotate, and count 32-n rotates right by n.
// - a left-justified n-bit insert at bit b uses shift 32-b, begin b, end b+n-1.
// - a right-justified n-bit insert at bit b uses shift 32-(b+n), begin b, end b+n-1.
// - a right-justified extract of n bits from b uses count b+n, begin 32-n, end 31.
// - a left-justified extract of n bits from b uses count b, begin 0, end n-1.
// - record variants set condition field zero from the value written to the destination.
module rmu_top (
  input  wire logic                              clock,
  input  wire logic                              rstn,
  input  wire logic                              issue_valid,
  input  wire rmu_pkg::rmu_op_e                  op,
  input  wire logic                              record,
  input  wire logic [rmu_pkg::WORD_W-1:0]        source_register,
  input  wire logic [rmu_pkg::WORD_W-1:0]        count_register,
  input  wire logic [rmu_pkg::WORD_W-1:0]        destination_register,
  input  wire logic [rmu_pkg::CNT_W-1:0]         shift_amount_immediate,
  input  wire logic [rmu_pkg::CNT_W-1:0]         mask_begin,
  input  wire logic [rmu_pkg::CNT_W-1:0]         mask_end,
  input  wire logic                              summary_overflow,
  output logic                                   result_valid,
  output logic [rmu_pkg::WORD_W-1:0]             result,
  output logic                                   condition_write,
  output logic [rmu_pkg::CR_FIELD_W-1:0]         condition_field_zero,
  output logic                                   op_error
);

  // ==========================================================================
  // functions

  // left rotate of a big-endian word: bits leaving bit 0 re-enter at bit 31
  function automatic logic [rmu_pkg::WORD_W-1:0] rotl32(
    input logic [rmu_pkg::WORD_W-1:0] value,
    input logic [rmu_pkg::CNT_W-1:0]  amount
  );
    logic [2*rmu_pkg::WORD_W-1:0] twice;
    twice  = {value, value} << amount;
    rotl32 = twice[2*rmu_pkg::WORD_W-1:rmu_pkg::WORD_W];
  endfunction

  // condition field zero from a signed compare of the result against zero
  function automatic logic [rmu_pkg::CR_FIELD_W-1:0] cr0_of(
    input logic [rmu_pkg::WORD_W-1:0] value,
    input logic                       so
  );
    logic [rmu_pkg::CR_FIELD_W-1:0] f;
    f = '0;
    f[rmu_pkg::CR0_LT_BIT] = value[rmu_pkg::WORD_W-1];
    f[rmu_pkg::CR0_GT_BIT] = !value[rmu_pkg::WORD_W-1] && (value != '0);
    f[rmu_pkg::CR0_EQ_BIT] = (value == '0);
    f[rmu_pkg::CR0_SO_BIT] = so;
    cr0_of = f;
  endfunction

  // ==========================================================================
  // capture stage: operands of the accepted instruction
  logic                            cap_valid_q,   cap_valid_d;
  logic                            cap_is_ins_q,  cap_is_ins_d;
  logic                            cap_record_q,  cap_record_d;
  logic                            cap_so_q,      cap_so_d;
  logic                            cap_err_q,     cap_err_d;
  logic [rmu_pkg::WORD_W-1:0]      cap_src_q,     cap_src_d;
  logic [rmu_pkg::WORD_W-1:0]      cap_dst_q,     cap_dst_d;
  logic [rmu_pkg::CNT_W-1:0]       cap_cnt_q,     cap_cnt_d;
  logic [rmu_pkg::CNT_W-1:0]       cap_mb_q,      cap_mb_d;
  logic [rmu_pkg::CNT_W-1:0]       cap_me_q,      cap_me_d;

  always_comb begin
    cap_valid_d  = 1'b0;
    cap_err_d    = 1'b0;
    cap_is_ins_d = cap_is_ins_q;
    cap_record_d = cap_record_q;
    cap_so_d     = cap_so_q;
    cap_src_d    = cap_src_q;
    cap_dst_d    = cap_dst_q;
    cap_cnt_d    = cap_cnt_q;
    cap_mb_d     = cap_mb_q;
    cap_me_d     = cap_me_q;
    if (issue_valid) begin
      cap_record_d = record;
      cap_so_d     = summary_overflow;
      cap_src_d    = source_register;
      cap_dst_d    = destination_register;
      cap_mb_d     = mask_begin;
      cap_me_d     = mask_end;
      unique case (op)
        rmu_pkg::RMU_OP_ROT_AND: begin
          cap_valid_d  = 1'b1;
          cap_is_ins_d = 1'b0;
          // only bits 27..31 count; upper count bits are dropped
          cap_cnt_d    = count_register[rmu_pkg::CNT_W-1:0];
        end
        rmu_pkg::RMU_OP_ROT_INSERT: begin
          cap_valid_d  = 1'b1;
          cap_is_ins_d = 1'b1;
          cap_cnt_d    = shift_amount_immediate;
        end
        default: begin
          // an illegal select produces no result and no condition write
          cap_err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cap_valid_q  <= 1'b0;
      cap_is_ins_q <= 1'b0;
      cap_record_q <= 1'b0;
      cap_so_q     <= 1'b0;
      cap_err_q    <= 1'b0;
      cap_src_q    <= rmu_pkg::RESULT_RST;
      cap_dst_q    <= rmu_pkg::RESULT_RST;
      cap_cnt_q    <= rmu_pkg::CNT_RST;
      cap_mb_q     <= rmu_pkg::CNT_RST;
      cap_me_q     <= rmu_pkg::CNT_RST;
    end else begin
      cap_valid_q  <= cap_valid_d;
      cap_is_ins_q <= cap_is_ins_d;
      cap_record_q <= cap_record_d;
      cap_so_q     <= cap_so_d;
      cap_err_q    <= cap_err_d;
      cap_src_q    <= cap_src_d;
      cap_dst_q    <= cap_dst_d;
      cap_cnt_q    <= cap_cnt_d;
      cap_mb_q     <= cap_mb_d;
      cap_me_q     <= cap_me_d;
    end
  end

  // ==========================================================================
  // mask generation
  rmu_mask_if mask_bus ();

  assign mask_bus.mask_begin = cap_mb_q;
  assign mask_bus.mask_end   = cap_me_q;

  rmu_mask_gen u_mask_gen (
    .m (mask_bus)
  );

  // ==========================================================================
  // datapath: rotate, then and or insert under the mask
  // the extract, insert and rotate idioms need no special case: they fall out
  // of the general rotate and mask with the right operands
  logic [rmu_pkg::WORD_W-1:0] rotated;
  logic [rmu_pkg::WORD_W-1:0] masked;
  logic [rmu_pkg::WORD_W-1:0] inserted;
  logic [rmu_pkg::WORD_W-1:0] datapath_out;

  always_comb begin
    rotated  = rotl32(cap_src_q, cap_cnt_q);
    masked   = rotated & mask_bus.mask;
    inserted = (rotated & mask_bus.mask) | (cap_dst_q & ~mask_bus.mask);
    datapath_out = cap_is_ins_q ? inserted : masked;
  end

  // ==========================================================================
  // result stage: registered outputs
  logic                            res_valid_q,  res_valid_d;
  logic [rmu_pkg::WORD_W-1:0]      res_q,        res_d;
  logic                            cr_wr_q,      cr_wr_d;
  logic [rmu_pkg::CR_FIELD_W-1:0]  cr0_q,        cr0_d;
  logic                            err_q,        err_d;

  always_comb begin
    res_valid_d = cap_valid_q;
    res_d       = res_q;
    cr_wr_d     = 1'b0;
    cr0_d       = cr0_q;
    err_d       = cap_err_q;
    if (cap_valid_q) begin
      res_d = datapath_out;
      if (cap_record_q) begin
        // plain variants hold the last field value and raise no write
        cr_wr_d = 1'b1;
        cr0_d   = cr0_of(datapath_out, cap_so_q);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      res_valid_q <= 1'b0;
      res_q       <= rmu_pkg::RESULT_RST;
      cr_wr_q     <= 1'b0;
      cr0_q       <= rmu_pkg::CR0_RST;
      err_q       <= 1'b0;
    end else begin
      res_valid_q <= res_valid_d;
      res_q       <= res_d;
      cr_wr_q     <= cr_wr_d;
      cr0_q       <= cr0_d;
      err_q       <= err_d;
    end
  end

  // ==========================================================================
  // outputs
  assign result_valid         = res_valid_q;
  assign result               = res_q;
  assign condition_write      = cr_wr_q;
  assign condition_field_zero = cr0_q;
  assign op_error             = err_q;

endmodule // rmu_top

//--- tb/rmu_checker.sv
/* rmu_checker: timing and condition field assertions on the rmu_top ports.
   assumes: bound to rmu_top, single clock domain. */
`timescale 1ns/1ps
module rmu_checker (
  input wire logic                   clock,
  input wire logic                   rstn,
  input wire logic                   issue_valid,
  input wire rmu_pkg::rmu_op_e       op,
  input wire logic                   record,
  input wire logic                   summary_overflow,
  input wire logic                   result_valid,
  input wire logic [31:0]            result,
  input wire logic                   condition_write,
  input wire logic [3:0]             condition_field_zero,
  input wire logic                   op_error
);
  // ====================
  // issue sequences
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  wire legal = (op == rmu_pkg::RMU_OP_ROT_AND) || (op == rmu_pkg::RMU_OP_ROT_INSERT);
  sequence s_ok; issue_valid && legal; endsequence
  sequence s_bad; issue_valid && !legal; endsequence
  sequence s_rec; issue_valid && legal && record; endsequence
  property p_lat; s_ok |-> ##2 result_valid && !op_error; endproperty
  property p_bad; s_bad |-> ##2 op_error && !result_valid && !condition_write; endproperty
  property p_rec; s_rec |-> ##2 condition_write; endproperty
  property p_plain; issue_valid && !record |-> ##2 !condition_write; endproperty
  property p_cr_hold; $changed(condition_field_zero) |-> condition_write; endproperty
  property p_cr_val;
    condition_write |-> condition_field_zero[3:1] ==
      {result[31], result != 32'h0 && !result[31], result == 32'h0};
  endproperty
  property p_so; s_rec |-> ##2 condition_field_zero[0] == $past(summary_overflow, 2); endproperty
  property p_res_hold; $changed(result) |-> result_valid; endproperty
  property p_cause; result_valid |-> $past(issue_valid, 2); endproperty
  property p_cw_pair; condition_write |-> result_valid; endproperty
  a_lat:      assert property (p_lat) else $error("result_valid late or missing");
  a_bad:      assert property (p_bad) else $error("illegal op not refused");
  a_rec:      assert property (p_rec) else $error("record op without write");
  a_plain:    assert property (p_plain) else $error("plain op wrote condition");
  a_cr_hold:  assert property (p_cr_hold) else $error("condition field moved");
  a_cr_val:   assert property (p_cr_val) else $error("condition field wrong");
  a_so:       assert property (p_so) else $error("overflow copy wrong");
  a_res_hold: assert property (p_res_hold) else $error("result moved");
  a_cause:    assert property (p_cause) else $error("result without issue");
  a_cw_pair:  assert property (p_cw_pair) else $error("write without result");
endmodule // rmu_checker

bind rmu_top rmu_checker i_rmu_checker (.clock(clock), .rstn(rstn),
  .issue_valid(issue_valid), .op(op), .record(record), .summary_overflow(summary_overflow),
  .result_valid(result_valid), .result(result), .condition_write(condition_write),
  .condition_field_zero(condition_field_zero), .op_error(op_error));

//--- tb/testbench.sv
/* testbench: self-checking bench of rmu_top with a reference model and queue.
   assumes: two-cycle issue-to-result latency, inputs driven at falling edge. */
`timescale 1ns/1ps
module testbench;
  typedef struct {logic err; logic [31:0] r; logic cw; logic [3:0] cr;} rmu_exp_s;
  logic clock, rstn, issue_valid, record, summary_overflow;
  rmu_pkg::rmu_op_e op;
  logic [31:0] source_register, count_register, destination_register, result, c;
  logic [4:0]  shift_amount_immediate, mask_begin, mask_end;
  logic        result_valid, condition_write, op_error;
  logic [3:0]  condition_field_zero, last_cr = 4'h0;
  logic [31:0] seed = 32'h0831840a;
  int          fails = 0, tests_run = 0;
  rmu_exp_s    q[$], e;
  int          bs[4] = '{0, 3, 17, 28}, ns[4] = '{0, 1, 13, 31};

  rmu_top i_rmu_top (.clock(clock), .rstn(rstn), .issue_valid(issue_valid), .op(op),
    .record(record), .source_register(source_register), .count_register(count_register),
    .destination_register(destination_register), .shift_amount_immediate(shift_amount_immediate),
    .mask_begin(mask_begin), .mask_end(mask_end), .summary_overflow(summary_overflow),
    .result_valid(result_valid), .result(result), .condition_write(condition_write),
    .condition_field_zero(condition_field_zero), .op_error(op_error));

  // ====================
  // reference model, big-endian bit numbers
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) seed = {seed[30:0], seed[31]^seed[21]^seed[1]^seed[0]};
    return seed;
  endfunction
  function automatic logic [31:0] mk(int mb, int me);
    logic [31:0] m;
    for (int p = 0; p < 32; p++)
      m[31-p] = (mb <= me) ? (p >= mb && p <= me) : (p >= mb || p <= me);
    return m;
  endfunction
  task automatic issue(input logic [1:0] o, input logic rec, input logic [31:0] s, cn, d,
                       input logic [4:0] sh, mb, me);
    rmu_exp_s x;
    logic [31:0] r, m, so;
    so = rnd();
    m = mk(mb, me);
    r = (o == 2'h1) ? (s << cn[4:0]) | (s >> (6'd32 - cn[4:0])) : (s << sh) | (s >> (6'd32 - sh));
    r = (o == 2'h1) ? (r & m) : ((r & m) | (d & ~m));
    x.err = !(o inside {2'h1, 2'h2});
    x.r = r;
    x.cw = rec && !x.err;
    x.cr = x.cw ? {r[31], r != 0 && !r[31], r == 0, so[0]} : last_cr;
    last_cr = x.cr;
    @(negedge clock);
    q.push_back(x);
    {issue_valid, record, summary_overflow} = {1'b1, rec, so[0]};
    op = rmu_pkg::rmu_op_e'(o);
    {source_register, count_register, destination_register} = {s, cn, d};
    {shift_amount_immediate, mask_begin, mask_end} = {sh, mb, me};
  endtask
  task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, ex, got);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ====================
  // output watcher: oldest note against each answer, looked at mid-cycle where outputs are settled
  always @(negedge clock) begin
    if (rstn && (result_valid === 1'b1 || op_error === 1'b1)) begin
      if (q.size() == 0) chk("spurious result", 32'h0, 32'h1);
      else begin
        e = q.pop_front();
        chk("op_error", e.err, op_error);
        chk("result_valid", !e.err, result_valid);
        if (!e.err) chk("result", e.r, result);
        chk("condition_write", e.cw, condition_write);
        chk("condition_field_zero", e.cr, condition_field_zero);
      end
    end
  end

  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    repeat (3000) @(posedge clock);
    fails++;
    summarize();
  end

  initial begin
    {rstn, issue_valid, record, summary_overflow} = 4'h0;
    op = rmu_pkg::RMU_OP_ROT_AND;
    {source_register, count_register, destination_register} = '0;
    {shift_amount_immediate, mask_begin, mask_end} = '0;
    repeat (2) @(posedge clock);
    @(negedge clock) rstn = 1;
    chk("reset field", 32'h0, condition_field_zero);
    // upper count bits carry noise, only the low five may matter
    foreach (ns[i]) begin
      c = rnd();
      issue(2'h1, 1'b1, rnd(), {c[31:5], 5'(ns[i])}, rnd(), 5'h0, 5'h00, 5'h1f);
      issue(2'h1, 1'b0, rnd(), {c[31:5], 5'(32 - ns[i])}, rnd(), 5'h0, 5'h00, 5'h1f);
    end
    foreach (bs[i]) begin
      issue(2'h2, 1'b1, rnd(), rnd(), rnd(), 5'(32-bs[i]), 5'(bs[i]), 5'(bs[i]+3));
      issue(2'h2, 1'b0, rnd(), rnd(), rnd(), 5'(28-bs[i]), 5'(bs[i]), 5'(bs[i]+3));
      issue(2'h1, 1'b1, rnd(), 32'(bs[i] + 4), rnd(), 5'h0, 5'h1c, 5'h1f);
      issue(2'h1, 1'b1, rnd(), 32'(bs[i]), rnd(), 5'h0, 5'h00, 5'h03);
    end
    issue(2'h0, 1'b1, rnd(), rnd(), rnd(), 5'h3, 5'h1, 5'h2);
    issue(2'h3, 1'b1, rnd(), rnd(), rnd(), 5'h3, 5'h1, 5'h2);
    // mid-run reset with the pipe drained: outputs and the held field must clear
    @(negedge clock) issue_valid = 0;
    repeat (4) @(negedge clock);
    rstn = 0;
    @(negedge clock) rstn = 1;
    last_cr = 4'h0;
    chk("reset result", 32'h0, result);
    chk("reset field again", 32'h0, condition_field_zero);
    // random back-to-back mix, wrapped masks included
    repeat (300) begin
      c = rnd();
      issue(c[0] ? 2'h1 : 2'h2, c[1], rnd(), rnd(), rnd(), c[8:4], c[13:9], c[18:14]);
    end
    @(negedge clock) issue_valid = 0;
    for (int i = 0; i < 20 && q.size() > 0; i++) @(posedge clock);
    chk("pending answers", 32'h0, 32'(q.size()));
    summarize();
  end
endmodule // testbench
